// *** include/flash_access_consts.svh ***
`ifndef FLASH_ACCESS_CONSTS_SVH
`define FLASH_ACCESS_CONSTS_SVH
// ****************************************
// register map
// ****************************************
`define FCS_IDX 8'h29
`define FCS_ADDR 12'h0a4
`define OP_ADDR 12'h0a8
`define OP_DATA 12'h0ac
`define OP_STAT 12'h0b0
`define FCS_RESET 8'h00
// ****************************************
// control field positions
// ****************************************
`define BIT_GO 0
`define BIT_ERASE 1
`define BIT_WHOLE 2
`define BIT_PROG 3
`define BIT_RDPROT 4
// ****************************************
// address layout
// ****************************************
`define SECTOR_BYTES 17'h01000
`define BOOT_BASE 16'hf000
`define SEC1_BASE 16'he000
`define MEM_4K 17'h01000
`define MEM_8K 17'h02000
`endif

// *** include/flash_access_pkg.sv ***
package flash_access_pkg;
   // access mode of the flash
   typedef enum logic [1:0] {
      mode_tool_type_v = 2'b00,
      mode_icp_type_v = 2'b01,
      mode_iap_type_v = 2'b10
   } flash_mode_type;
   // operation sequencer states, gray along path
   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_check = 2'b01,
      st_run = 2'b11,
      st_done = 2'b10
   } op_state_type;
   // request handed to the flash array
   typedef struct packed {
      logic prog;
      logic erase_sector;
      logic erase_all;
      logic [15:0] addr;
      logic [7:0] data;
   } flash_op_type;
endpackage : flash_access_pkg

// *** hw/flash_sector_access_control.sv ***
// Register access over APB was chosen for this implementation.
`include "flash_access_consts.svh"
module flash_sector_access_control #(
   parameter logic [16:0] MEM_SIZE = 17'h08000
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic [11:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire flash_access_pkg::flash_mode_type mode_i,
   input wire logic cpu_read_i,
   input wire logic [15:0] cpu_addr_i,
   input wire logic ext_read_i,
   output logic read_allow_o,
   output flash_access_pkg::flash_op_type op_o,
   output logic op_valid_o,
   input wire logic op_done_i,
   input wire logic tool_attached_i,
   output logic pins_to_link_o,
   input wire logic debug_link_clock_i,
   input wire logic debug_link_data_i,
   output logic debug_link_data_o,
   output logic debug_link_data_oe_n_o,
   output logic link_active_o
);
   import flash_access_pkg::*;
   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [7:0] ctrl;
      logic [15:0] addr;
      logic [7:0] data;
      logic rd_prot;
      logic rd_prot_d;
      logic erase_pend;
      logic refused;
      logic busy;
      op_state_type st;
      flash_op_type op;
      logic [1:0] att_sync;
      logic [1:0] tgl_sync;
      logic tgl_seen;
      logic [31:0] rdata;
      logic ready;
   } state_type;
   state_type r, next_r;
   // ****************************************
   // link domain: bit shifter on link clock
   // ****************************************
   logic link_toggle; // flips on each received bit
   logic link_out; // echoed data bit
   always_ff @(posedge debug_link_clock_i) begin
      if (rst_i) begin
         link_toggle <= 1'b0;
         link_out <= 1'b0;
      end else begin
         link_toggle <= ~link_toggle;
         link_out <= debug_link_data_i;
      end
   end
   assign debug_link_data_o = link_out;
   assign debug_link_data_oe_n_o = ~r.att_sync[1];
   // ****************************************
   // decode helpers
   // ****************************************
   // sector index of an address: 0 from BOOT_BASE up, 1 from SEC1_BASE up, 2 below
   function automatic logic [1:0] sector_of(input logic [15:0] a);
      if (a >= `BOOT_BASE) begin
         sector_of = 2'd0;
      end else if (a >= `SEC1_BASE) begin
         sector_of = 2'd1;
      end else begin
         sector_of = 2'd2;
      end
   endfunction : sector_of
   // does the sector exist in this size
   function automatic logic sector_exists(input logic [1:0] s);
      if (MEM_SIZE <= `MEM_4K) begin
         sector_exists = (s == 2'd0);
      end else if (MEM_SIZE <= `MEM_8K) begin
         sector_exists = (s <= 2'd1);
      end else begin
         sector_exists = (s <= 2'd2);
      end
   endfunction : sector_exists
   // may this sector be written in this mode
   function automatic logic write_ok(input logic [1:0] s, input flash_mode_type m);
      if (m == mode_iap_type_v) begin
         write_ok = (s != 2'd0);
      end else begin
         write_ok = 1'b1;
      end
   endfunction : write_ok
   // ****************************************
   // read protection gate
   // ****************************************
   assign read_allow_o = cpu_read_i & ~(ext_read_i & r.rd_prot);
   assign pins_to_link_o = r.att_sync[1];
   assign link_active_o = r.tgl_seen;
   assign op_o = r.op;
   assign op_valid_o = (r.st == st_run);
   assign prdata_o = r.rdata;
   assign pready_o = r.ready;
   assign pslverr_o = 1'b0;
   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      logic [1:0] sec;
      logic wr;
      logic rd;
      sec = sector_of(r.addr);
      // a write commits at the edge where the master samples pready high
      wr = psel_i & penable_i & pwrite_i & r.ready;
      rd = psel_i & penable_i & ~pwrite_i & ~r.ready;
      next_r = r;
      next_r.ready = psel_i & penable_i & ~r.ready;
      next_r.att_sync = {r.att_sync[0], tool_attached_i};
      next_r.tgl_sync = {r.tgl_sync[0], link_toggle};
      next_r.tgl_seen = r.tgl_sync[1];
      next_r.rd_prot_d = r.rd_prot;
      next_r.ctrl[`BIT_GO] = 1'b0;
      // register writes
      if (wr) begin
         unique case (paddr_i)
            `FCS_ADDR: begin
               next_r.ctrl = pwdata_i[7:0];
               next_r.rd_prot = pwdata_i[`BIT_RDPROT];
            end
            `OP_ADDR: next_r.addr = pwdata_i[15:0];
            `OP_DATA: next_r.data = pwdata_i[7:0];
            default: ;
         endcase
      end
      // unmapped or write cycles read zero
      next_r.rdata = 32'h0000_0000;
      if (rd) begin
         unique case (paddr_i)
            `FCS_ADDR: next_r.rdata = {24'h000000, r.ctrl};
            `OP_ADDR: next_r.rdata = {16'h0000, r.addr};
            `OP_DATA: next_r.rdata = {24'h000000, r.data};
            `OP_STAT: next_r.rdata = {28'h0000000, r.erase_pend, r.refused, r.busy, r.rd_prot};
            default: ;
         endcase
      end
      // operation sequencer
      unique case (r.st)
         st_idle: begin
            next_r.busy = 1'b0;
            if (r.erase_pend) begin
               next_r.op = '{prog: 1'b0, erase_sector: 1'b0, erase_all: 1'b1, addr: 16'h0000, data: 8'h00};
               next_r.busy = 1'b1;
               next_r.st = st_run;
            end else if (r.ctrl[`BIT_GO]) begin
               next_r.busy = 1'b1;
               next_r.st = st_check;
            end
         end
         st_check: begin
            if (r.rd_prot | ~sector_exists(sec) | (~write_ok(sec, mode_i) & ~r.ctrl[`BIT_WHOLE]) |
                (r.ctrl[`BIT_WHOLE] & (mode_i == mode_iap_type_v))) begin
               next_r.refused = 1'b1;
               next_r.st = st_done;
            end else begin
               next_r.refused = 1'b0;
               next_r.op.prog = r.ctrl[`BIT_PROG] & ~r.ctrl[`BIT_ERASE];
               next_r.op.erase_sector = r.ctrl[`BIT_ERASE] & ~r.ctrl[`BIT_WHOLE];
               next_r.op.erase_all = r.ctrl[`BIT_ERASE] & r.ctrl[`BIT_WHOLE];
               next_r.op.addr = r.addr;
               next_r.op.data = r.data;
               next_r.st = st_run;
            end
         end
         st_run: begin
            if (op_done_i) begin
               if (r.op.erase_all) begin
                  next_r.erase_pend = 1'b0;
               end
               next_r.st = st_done;
            end
         end
         st_done: begin
            next_r.op = '0;
            next_r.busy = 1'b0;
            next_r.st = st_idle;
         end
      endcase
      // protection removed: queue whole erase, set wins over a same-cycle clear
      if (r.rd_prot_d & ~r.rd_prot) begin
         next_r.erase_pend = 1'b1;
      end
   end
   // ****************************************
   // register stage
   // ****************************************
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         r <= '0;
         r.ctrl <= `FCS_RESET;
         r.st <= st_idle;
      end else begin
         r <= next_r;
      end
   end
endmodule : flash_sector_access_control

// *** tb/flash_array_model.sv ***
module flash_array_model (
   input wire logic clk_sys_i,
   input wire flash_access_pkg::flash_op_type op_i,
   input wire logic op_valid_i,
   input wire logic [3:0] delay_i,
   output logic op_done_o
);
   import flash_access_pkg::*;
   logic [7:0] mem [0:65535]; // byte array, erased value ff
   int cnt = 0; // wait cycles spent on the current request
   // sector of an address: top page 0, next page 1, rest 2
   function automatic int sec(input logic [15:0] a);
      return (a[15:12] == 4'hf) ? 0 : ((a[15:12] == 4'he) ? 1 : 2);
   endfunction : sec
   initial op_done_o = 1'b0;
   initial foreach (mem[k]) mem[k] = 8'hff;
   // answers each request after delay_i extra cycles
   always @(posedge clk_sys_i) begin
      op_done_o <= 1'b0;
      if (op_valid_i && !op_done_o && cnt++ >= delay_i) begin
         cnt = 0;
         op_done_o <= 1'b1;
         if (op_i.prog) mem[op_i.addr] = op_i.data;
         for (int k = 0; k < 65536; k++) begin
            if (op_i.erase_all || (op_i.erase_sector && sec(16'(k)) == sec(op_i.addr))) mem[k] = 8'hff;
         end
      end
   end
endmodule : flash_array_model

// *** tb/flash_sector_access_control_assertions.sv ***
module flash_sector_access_control_assertions
   import flash_access_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire flash_access_pkg::flash_mode_type mode_i,
   input wire logic cpu_read_i,
   input wire logic ext_read_i,
   input wire logic read_allow_o,
   input wire flash_access_pkg::flash_op_type op_o,
   input wire logic op_valid_o,
   input wire logic op_done_i,
   input wire logic tool_attached_i,
   input wire logic pins_to_link_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   AST_NO_ERR: assert property (!pslverr_o) else $error("slave error raised");
   AST_ONE_WAIT: assert property (psel_i && penable_i && !pready_o |=> pready_o) else $error("no answer");
   AST_PULSE: assert property (pready_o |=> !pready_o) else $error("ready too long");
   AST_RD_OFF: assert property (!cpu_read_i |-> !read_allow_o) else $error("read allowed");
   AST_RD_ON: assert property (cpu_read_i && !ext_read_i |-> read_allow_o) else $error("read blocked");
   AST_ONE_KIND: assert property (op_valid_o |-> $onehot({op_o.prog, op_o.erase_sector, op_o.erase_all}))
      else $error("mixed request");
   AST_HOLD: assert property (op_valid_o && !op_done_i |=> op_valid_o && $stable(op_o)) else $error("request moved");
   AST_END: assert property (op_valid_o && op_done_i |=> !op_valid_o) else $error("request stuck");
   AST_IAP_BOOT: assert property (op_valid_o && mode_i == mode_iap_type_v |-> !op_o.erase_all && op_o.addr[15:12] != 4'hf)
      else $error("boot sector touched");
   AST_PINS: assert property ($rose(tool_attached_i) |-> ##[1:3] pins_to_link_o) else $error("pins not taken");
   cover property (op_valid_o && op_o.erase_all);
   cover property (op_valid_o && op_o.prog);
   cover property (op_valid_o && op_o.erase_sector);
endmodule : flash_sector_access_control_assertions
bind flash_sector_access_control flash_sector_access_control_assertions u_chk (.clk_sys_i, .rst_i, .psel_i, .penable_i,
   .pready_o, .pslverr_o, .mode_i, .cpu_read_i, .ext_read_i, .read_allow_o, .op_o, .op_valid_o, .op_done_i,
   .tool_attached_i, .pins_to_link_o);

// *** tb/flash_sector_access_control_tb_top.sv ***
`include "flash_access_consts.svh"
module flash_sector_access_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import flash_access_pkg::*;
   logic clk_sys_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, cpu_read_i = 0, ext_read_i = 0;
   logic tool_attached_i = 0, debug_link_clock_i = 0, debug_link_data_i = 0, pready_o, pslverr_o, read_allow_o;
   logic op_valid_o, op_done_i, pins_to_link_o, debug_link_data_o, debug_link_data_oe_n_o, link_active_o;
   logic [11:0] paddr_i = 0;
   logic [31:0] pwdata_i = 0, prdata_o, r;
   logic [3:0] delay = 0; // model answer delay
   flash_mode_type mode_i = mode_tool_type_v;
   flash_op_type op_o;
   int n_mismatch = 0, checks_done = 0;
   localparam flash_mode_type tl = mode_tool_type_v, ic = mode_icp_type_v, ia = mode_iap_type_v;
   // mode, control, address, data, expected byte, expected refusal
   typedef struct packed {flash_mode_type m; logic [7:0] c; logic [15:0] a; logic [7:0] d, e; logic f;} row_type;
   row_type rows [8] = '{'{tl, 8'h09, 16'hf010, 8'h5a, 8'h5a, 1'b0}, '{ic, 8'h09, 16'he020, 8'h3c, 8'h3c, 1'b0},
      '{ia, 8'h09, 16'hf011, 8'h77, 8'hff, 1'b1}, '{ia, 8'h09, 16'h8000, 8'h11, 8'h11, 1'b0},
      '{ia, 8'h03, 16'hf010, 8'h00, 8'h5a, 1'b1}, '{ia, 8'h03, 16'he020, 8'h00, 8'hff, 1'b0},
      '{ia, 8'h07, 16'hf010, 8'h00, 8'h5a, 1'b1}, '{tl, 8'h07, 16'h8000, 8'h00, 8'hff, 1'b0}};
   initial forever #10 clk_sys_i = ~clk_sys_i;
   initial begin
      #1.7;
      forever #3 debug_link_clock_i = ~debug_link_clock_i;
   end
   flash_sector_access_control u_flash_sector_access_control (.clk_sys_i, .rst_i, .paddr_i, .psel_i, .penable_i,
      .pwrite_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .mode_i, .cpu_read_i, .cpu_addr_i(16'h0000),
      .ext_read_i, .read_allow_o, .op_o, .op_valid_o, .op_done_i, .tool_attached_i, .pins_to_link_o,
      .debug_link_clock_i, .debug_link_data_i, .debug_link_data_o, .debug_link_data_oe_n_o, .link_active_o);
   flash_array_model u_flash_array_model (.clk_sys_i, .op_i(op_o), .op_valid_i(op_valid_o), .delay_i(delay),
      .op_done_o(op_done_i));
   function automatic logic [7:0] m(input logic [15:0] a);
      return u_flash_array_model.mem[a];
   endfunction : m
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // one bus transfer, read data lands in r
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge clk_sys_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_sys_i);
      penable_i <= 1'b1;
      // look at settled outputs; the transfer completes at the next rising edge
      do @(negedge clk_sys_i); while (pready_o !== 1'b1 && ++t < 20);
      if (t >= 20) n_mismatch++;
      r = prdata_o;
      @(posedge clk_sys_i);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb
   // load a request, start it and poll until idle
   task automatic op(input logic [15:0] a, input logic [7:0] d, input logic [7:0] c);
      int t;
      t = 0;
      apb(1'b1, `OP_ADDR, {16'h0000, a});
      apb(1'b1, `OP_DATA, {24'h000000, d});
      apb(1'b1, `FCS_ADDR, {24'h000000, c});
      do apb(1'b0, `OP_STAT, 32'h0); while ((r[1] || r[3]) && ++t < 50);
   endtask : op
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : summarize
   initial begin
      #100us;
      n_mismatch++;
      summarize();
   end
   initial begin
      repeat (5) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      apb(1'b1, 12'h100, 32'hff);
      apb(1'b0, `FCS_ADDR, 32'h0);
      chk(r, 32'h0);
      apb(1'b0, 12'h100, 32'h0);
      chk(r, 32'h0);
      $display("reset test done");
      foreach (rows[i]) begin
         mode_i <= rows[i].m;
         delay <= 4'(i * 3);
         op(rows[i].a, rows[i].d, rows[i].c);
         chk(m(rows[i].a), rows[i].e);
         chk(r[2], rows[i].f);
         $display("row %0d done", i);
      end
      // readout protection, then its removal
      op(16'h8000, 8'h22, 8'h09);
      apb(1'b1, `FCS_ADDR, 32'h10);
      apb(1'b0, `OP_STAT, 32'h0);
      chk(r[0], 1'b1);
      cpu_read_i <= 1'b1;
      ext_read_i <= 1'b1;
      @(posedge clk_sys_i);
      ext_read_i <= 1'b1;
      @(posedge clk_sys_i);
      chk(read_allow_o, 1'b0);
      op(16'h8000, 8'h33, 8'h19);
      chk(m(16'h8000), 8'h22);
      op(16'h8000, 8'h00, 8'h00);
      chk(m(16'h8000), 8'hff);
      $display("protection test done");
      // tool attach takes the link pins
      mode_i <= mode_icp_type_v;
      tool_attached_i <= 1'b1;
      debug_link_data_i <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
      chk(pins_to_link_o, 1'b1);
      chk(debug_link_data_oe_n_o, 1'b0);
      chk(debug_link_data_o, 1'b1);
      $display("link test done");
      summarize();
   end
endmodule : flash_sector_access_control_tb_top
